// ---- include/mbc_defines.svh ----
// offsets, field positions, reset values and timing counts for motor bridge control
`ifndef MBC_DEFINES_SVH
`define MBC_DEFINES_SVH

`define MBC_OFS_FRAME      4'h0
`define MBC_OFS_CONFIG     4'h4
`define MBC_OFS_STATUS     4'h8
`define MBC_OFS_STATE      4'hC

`define MBC_FRAME_SEL_BIT  0
`define MBC_CFG_DC_MODE    13
`define MBC_NRM_DIR_A      15
`define MBC_NRM_DIR_B      14
`define MBC_NRM_DIR_C      13
`define MBC_NRM_HS1_ON     12
`define MBC_NRM_HS2_ON     11
`define MBC_NRM_LS_HI      10
`define MBC_NRM_LS_LO      9
`define MBC_NRM_STEP_A_INV 8
`define MBC_NRM_STEP_B_INV 7

`define MBC_NORMAL_RST     16'h0000
`define MBC_CONFIG_RST     16'h0001

`define MBC_CLK_NS         4
`define MBC_DEGLITCH_NS    2000
`define MBC_DEAD_NS        1000
`define MBC_OSC_NS         5000
`define MBC_OFF_TICKS      10
`define MBC_DEGLITCH_CYC   ((`MBC_DEGLITCH_NS + `MBC_CLK_NS - 1) / `MBC_CLK_NS)
`define MBC_DEAD_CYC       ((`MBC_DEAD_NS + `MBC_CLK_NS - 1) / `MBC_CLK_NS)
`define MBC_OSC_CYC        (`MBC_OSC_NS / `MBC_CLK_NS)

`endif

// ---- include/mbc_pkg.sv ----
// types shared by the motor bridge control block
`default_nettype none
package mbc_pkg;

  typedef enum logic [1:0] {
    MBC_ST_RUN = 2'b01,
    MBC_ST_OFF = 2'b10
  } mbc_state_type;

  typedef enum logic [1:0] {
    MBC_SP_1V5 = 2'h0,
    MBC_SP_1V8 = 2'h1,
    MBC_SP_2V5 = 2'h2
  } mbc_setpoint_type;

  typedef struct packed {
    logic hs1;
    logic ls1;
    logic hs2;
    logic ls2;
  } mbc_gate_type;

endpackage
`default_nettype wire

// ---- rtl/mbc_top.sv ----
// motor bridge control: dc bridges, driver c, protection, supply decisions
//
// Overview of operation
// - config bit 13: 0 step, 1 dc
// - dc mode gp low sides, step mode gp highs
// - each bridge output follows its pwm input
// - direction reversal switches bridge immediately
// - over-current must persist past deglitch interval
// - qualified over-current starts bridge off-timer
// - floating pwm reads low, driver safe
// - step outputs off when supply exceeds 20 V
// - step pairs gated by driver c pwms
// - phase off turns counterphase on
// - dead time between phase and counterphase
// - high side 1: serial dir/on, pwm a
// - three-state select picks core set-point
// - switchers clocked at 200 kHz, may skip
// - driver thermal shutdown disables that driver's pwm and step drive, not its serial on bits
// - core regulator needs 3.3 V, thermal off
// - 5 V select low switching, high linear
// - frame bit 0 picks config or normal
// - reset: step outputs off, dc lows on
`timescale 1ns/10ps
`default_nettype none
`include "mbc_defines.svh"

module mbc_top
  import mbc_pkg::*;
#(
  parameter int DEGLITCH_CYC = `MBC_DEGLITCH_CYC,
  parameter int DEAD_CYC     = `MBC_DEAD_CYC,
  parameter int OSC_CYC      = `MBC_OSC_CYC,
  parameter int OFF_TICKS    = `MBC_OFF_TICKS
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output var  logic [31:0]      reg_rdata,
  input  wire logic             bridge_a_pwm_in,
  input  wire logic             bridge_b_pwm_in,
  input  wire logic             drv_c_pwm_in_a,
  input  wire logic             drv_c_pwm_in_b,
  input  wire logic [2:0]       oc_high_in,
  input  wire logic [2:0]       oc_low_in,
  input  wire logic [2:0]       drv_tsd_in,
  input  wire logic             core_tsd_in,
  input  wire logic             supply_over_20v_in,
  input  wire logic             v33_stable_in,
  input  wire logic             reg5_mode_select,
  input  wire logic             core_sel_probe_up_in,
  input  wire logic             core_sel_probe_dn_in,
  input  wire logic             reg5_fb_high_in,
  input  wire logic             reg33_fb_high_in,
  output var  mbc_gate_type     bridge_a_gate,
  output var  mbc_gate_type     bridge_b_gate,
  output var  logic             drv_c_dc_out_a,
  output var  logic             drv_c_dc_out_b,
  output var  logic [3:0]       drv_c_low_gate,
  output var  logic             reg5_linear_mode,
  output var  logic             reg5_switch,
  output var  logic             reg33_switch,
  output var  logic             core_reg_en,
  output var  mbc_setpoint_type core_reg_setpoint_select
);

  localparam int NSYNC = 21;

  // pins pass two flops before any logic reads them
  logic [NSYNC-1:0] meta_ff;
  logic [NSYNC-1:0] sync_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= {bridge_a_pwm_in, bridge_b_pwm_in, drv_c_pwm_in_a,
                  drv_c_pwm_in_b, oc_high_in, oc_low_in, drv_tsd_in,
                  core_tsd_in, supply_over_20v_in, v33_stable_in,
                  reg5_mode_select, core_sel_probe_up_in,
                  core_sel_probe_dn_in, reg5_fb_high_in, reg33_fb_high_in};
      sync_ff <= meta_ff;
    end
  end

  logic       s_pwm_a, s_pwm_b, s_pwm_ca, s_pwm_cb;
  logic [2:0] s_oc, s_tsd;
  logic       s_core_tsd, s_over20, s_v33, s_mode5, s_pu, s_pd;
  logic       s_fb5, s_fb33;
  always_comb begin
    s_pwm_a    = sync_ff[20];
    s_pwm_b    = sync_ff[19];
    s_pwm_ca   = sync_ff[18];
    s_pwm_cb   = sync_ff[17];
    s_oc       = sync_ff[16:14] | sync_ff[13:11];
    s_tsd      = sync_ff[10:8];
    s_core_tsd = sync_ff[7];
    s_over20   = sync_ff[6];
    s_v33      = sync_ff[5];
    s_mode5    = sync_ff[4];
    s_pu       = sync_ff[3];
    s_pd       = sync_ff[2];
    s_fb5      = sync_ff[1];
    s_fb33     = sync_ff[0];
  end

  function automatic mbc_gate_type bridge_drive(input logic pwm,
                                                input logic rev,
                                                input logic en);
    mbc_gate_type g;
    g = '0;
    if (en) begin
      // reversal simply swaps legs: current brakes through the new path
      g.hs1 = !rev && pwm;
      g.ls2 = !rev;
      g.hs2 = rev && pwm;
      g.ls1 = rev;
    end
    return g;
  endfunction

  // register file and status
  logic [15:0] normal_ff, nxt_normal;
  logic [15:0] config_ff, nxt_config;
  logic [6:0]  status_ff, nxt_status;
  logic [31:0] nxt_rdata;
  logic [6:0]  status_set;
  logic        dc_mode;
  // off-timer state per bridge, read by the state register below
  logic [2:0]  off_act;
  always_comb begin
    nxt_normal = normal_ff;
    nxt_config = config_ff;
    nxt_rdata  = '0;
    if (reg_wr && reg_addr == `MBC_OFS_FRAME) begin
      if (reg_wdata[`MBC_FRAME_SEL_BIT])
        nxt_config = reg_wdata[15:0];
      else
        nxt_normal = reg_wdata[15:0];
    end
    // set wins over a write-one clear in the same cycle
    nxt_status = status_ff | status_set;
    if (reg_wr && reg_addr == `MBC_OFS_STATUS)
      nxt_status = (status_ff & ~reg_wdata[6:0]) | status_set;
    if (reg_rd) begin
      case (reg_addr)
        `MBC_OFS_FRAME:  nxt_rdata = {16'h0000, normal_ff};
        `MBC_OFS_CONFIG: nxt_rdata = {16'h0000, config_ff};
        `MBC_OFS_STATUS: nxt_rdata = {25'h0000000, status_ff};
        `MBC_OFS_STATE:  nxt_rdata = {26'h0000000, core_reg_setpoint_select,
                                      off_act, dc_mode};
        default:         nxt_rdata = '0;
      endcase
    end
  end
  assign dc_mode = config_ff[`MBC_CFG_DC_MODE];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      normal_ff <= `MBC_NORMAL_RST;
      config_ff <= `MBC_CONFIG_RST;
      status_ff <= '0;
      reg_rdata <= '0;
    end else begin
      normal_ff <= nxt_normal;
      config_ff <= nxt_config;
      status_ff <= nxt_status;
      reg_rdata <= nxt_rdata;
    end
  end

  // 200 kHz oscillator as a one-cycle enable
  logic [11:0] osc_cnt_ff, nxt_osc_cnt;
  logic        osc_tick, osc_half;
  always_comb begin
    osc_tick    = osc_cnt_ff == 12'(OSC_CYC - 1);
    osc_half    = osc_cnt_ff == 12'(OSC_CYC / 2);
    nxt_osc_cnt = osc_tick ? 12'h000 : osc_cnt_ff + 12'h001;
  end

  // over-current deglitch and off-timer, one per bridge (a, b, c)
  mbc_state_type oc_st_ff [3];
  mbc_state_type nxt_oc_st [3];
  logic [11:0]   dg_cnt_ff [3];
  logic [11:0]   nxt_dg_cnt [3];
  logic [7:0]    off_cnt_ff [3];
  logic [7:0]    nxt_off_cnt [3];
  always_comb begin
    status_set = {s_core_tsd, s_tsd, 3'b000};
    for (int i = 0; i < 3; i++) begin
      nxt_oc_st[i]   = oc_st_ff[i];
      nxt_dg_cnt[i]  = s_oc[i] ? dg_cnt_ff[i] : 12'h000;
      nxt_off_cnt[i] = off_cnt_ff[i];
      off_act[i]     = oc_st_ff[i] != MBC_ST_RUN;
      case (oc_st_ff[i])
        MBC_ST_RUN: begin
          if (s_oc[i]) begin
            if (dg_cnt_ff[i] >= 12'(DEGLITCH_CYC - 1)) begin
              nxt_oc_st[i]   = MBC_ST_OFF;
              nxt_off_cnt[i] = 8'(OFF_TICKS);
              nxt_dg_cnt[i]  = 12'h000;
              status_set[i]  = 1'b1;
            end else begin
              nxt_dg_cnt[i] = dg_cnt_ff[i] + 12'h001;
            end
          end
        end
        MBC_ST_OFF: begin
          // bridge held off for roughly 25 deglitch times
          nxt_dg_cnt[i] = 12'h000;
          if (osc_tick) begin
            if (off_cnt_ff[i] <= 8'h01)
              nxt_oc_st[i] = MBC_ST_RUN;
            nxt_off_cnt[i] = off_cnt_ff[i] - 8'h01;
          end
        end
        default: nxt_oc_st[i] = MBC_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_cnt_ff <= '0;
      for (int i = 0; i < 3; i++) begin
        oc_st_ff[i]   <= MBC_ST_RUN;
        dg_cnt_ff[i]  <= '0;
        off_cnt_ff[i] <= '0;
      end
    end else begin
      osc_cnt_ff <= nxt_osc_cnt;
      for (int i = 0; i < 3; i++) begin
        oc_st_ff[i]   <= nxt_oc_st[i];
        dg_cnt_ff[i]  <= nxt_dg_cnt[i];
        off_cnt_ff[i] <= nxt_off_cnt[i];
      end
    end
  end

  // step pairs: phase/counterphase with dead time, pair 0 = a, 1 = b
  logic [1:0]  pair_ff [2];
  logic [1:0]  nxt_pair [2];
  logic [11:0] dt_cnt_ff [2];
  logic [11:0] nxt_dt_cnt [2];
  logic        step_run;
  logic [1:0]  want;
  logic [1:0]  pair_pwm;
  always_comb begin
    // pulled-down pin reads low: phase stays off
    pair_pwm = {s_pwm_cb, s_pwm_ca};
    step_run = !dc_mode && !s_over20 && !s_tsd[2] && !off_act[2];
    want     = '0;
    for (int p = 0; p < 2; p++) begin
      want          = step_run ? {pair_pwm[p], !pair_pwm[p]} : 2'b00;
      nxt_pair[p]   = pair_ff[p];
      nxt_dt_cnt[p] = dt_cnt_ff[p];
      if (want == pair_ff[p]) begin
        nxt_dt_cnt[p] = 12'(DEAD_CYC);
      end else if (pair_ff[p] != 2'b00) begin
        // turn-off is immediate, turn-on waits out the dead time
        nxt_pair[p]   = pair_ff[p] & want;
        nxt_dt_cnt[p] = 12'(DEAD_CYC);
      end else if (want == 2'b00 || dt_cnt_ff[p] <= 12'h001) begin
        nxt_pair[p] = want;
      end else begin
        nxt_dt_cnt[p] = dt_cnt_ff[p] - 12'h001;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < 2; p++) begin
        pair_ff[p]   <= 2'b00;
        dt_cnt_ff[p] <= '0;
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        pair_ff[p]   <= nxt_pair[p];
        dt_cnt_ff[p] <= nxt_dt_cnt[p];
      end
    end
  end

  // output gates, regulators and strap capture
  mbc_gate_type     nxt_ga, nxt_gb, gc;
  logic             nxt_hs1, nxt_hs2, nxt_sw5, nxt_sw33;
  logic [3:0]       nxt_low;
  logic [1:0]       settle_ff, nxt_settle;
  mbc_setpoint_type nxt_sp;
  always_comb begin
    nxt_ga = bridge_drive(s_pwm_a, normal_ff[`MBC_NRM_DIR_A],
                          !s_tsd[0] && !off_act[0]);
    nxt_gb = bridge_drive(s_pwm_b, normal_ff[`MBC_NRM_DIR_B],
                          !s_tsd[1] && !off_act[1]);
    gc     = bridge_drive(s_pwm_ca, normal_ff[`MBC_NRM_DIR_C],
                          !s_tsd[2] && !off_act[2]);
    if (dc_mode) begin
      nxt_hs1 = gc.hs1 || normal_ff[`MBC_NRM_HS1_ON];
      nxt_hs2 = gc.hs2;
      nxt_low = {normal_ff[`MBC_NRM_LS_HI], normal_ff[`MBC_NRM_LS_LO],
                 gc.ls2, gc.ls1};
    end else begin
      nxt_hs1 = normal_ff[`MBC_NRM_HS1_ON];
      nxt_hs2 = normal_ff[`MBC_NRM_HS2_ON];
      nxt_low = {pair_ff[1][normal_ff[`MBC_NRM_STEP_B_INV]],
                 pair_ff[1][!normal_ff[`MBC_NRM_STEP_B_INV]],
                 pair_ff[0][normal_ff[`MBC_NRM_STEP_A_INV]],
                 pair_ff[0][!normal_ff[`MBC_NRM_STEP_A_INV]]};
    end
    // switch on at tick unless feedback is already high: cycle skipping
    nxt_sw5 = reg5_switch;
    nxt_sw33 = reg33_switch;
    if (osc_tick) begin
      nxt_sw5  = !s_mode5 && !s_fb5;
      nxt_sw33 = !s_fb33;
    end else if (osc_half) begin
      nxt_sw5  = 1'b0;
      nxt_sw33 = 1'b0;
    end
    // strap read once, one cycle after the sync chain has filled
    nxt_settle = settle_ff;
    nxt_sp     = core_reg_setpoint_select;
    if (settle_ff != 2'h3) begin
      nxt_settle = settle_ff + 2'h1;
      if (settle_ff == 2'h2) begin
        if (!s_pu)
          nxt_sp = MBC_SP_1V5;
        else if (s_pd)
          nxt_sp = MBC_SP_1V8;
        else
          nxt_sp = MBC_SP_2V5;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bridge_a_gate            <= '{hs1: 1'b0, ls1: 1'b1,
                                    hs2: 1'b0, ls2: 1'b1};
      bridge_b_gate            <= '{hs1: 1'b0, ls1: 1'b1,
                                    hs2: 1'b0, ls2: 1'b1};
      drv_c_dc_out_a           <= 1'b0;
      drv_c_dc_out_b           <= 1'b0;
      drv_c_low_gate           <= 4'h0;
      reg5_linear_mode         <= 1'b0;
      reg5_switch              <= 1'b0;
      reg33_switch             <= 1'b0;
      core_reg_en              <= 1'b0;
      settle_ff                <= 2'h0;
      core_reg_setpoint_select <= MBC_SP_1V5;
    end else begin
      bridge_a_gate            <= nxt_ga;
      bridge_b_gate            <= nxt_gb;
      drv_c_dc_out_a           <= nxt_hs1;
      drv_c_dc_out_b           <= nxt_hs2;
      drv_c_low_gate           <= nxt_low;
      reg5_linear_mode         <= s_mode5;
      reg5_switch              <= nxt_sw5;
      reg33_switch             <= nxt_sw33;
      core_reg_en              <= s_v33 && !s_core_tsd;
      settle_ff                <= nxt_settle;
      core_reg_setpoint_select <= nxt_sp;
    end
  end

endmodule // mbc_top
`default_nettype wire

// ---- dv/mbc_top_checker.sv ----
// port assertions for motor bridge control
`timescale 1ns/10ps
`default_nettype none
module mbc_top_checker
  import mbc_pkg::*;
#(
  parameter int DEGLITCH_CYC = 8
) (
  input wire logic         clock,
  input wire logic         arst_n,
  input wire logic [3:0]   reg_addr,
  input wire logic [31:0]  reg_wdata,
  input wire logic         reg_wr,
  input wire logic         reg_rd,
  input wire logic [31:0]  reg_rdata,
  input wire logic         bridge_a_pwm_in,
  input wire logic [2:0]   oc_high_in,
  input wire logic [2:0]   oc_low_in,
  input wire logic [2:0]   drv_tsd_in,
  input wire logic         core_tsd_in,
  input wire logic         reg5_mode_select,
  input wire mbc_gate_type bridge_a_gate,
  input wire mbc_gate_type bridge_b_gate,
  input wire logic [3:0]   drv_c_low_gate,
  input wire logic         reg5_linear_mode,
  input wire logic         reg5_switch,
  input wire logic         core_reg_en
);
  // consecutive over-current samples on bridge a, saturating
  int oc_cnt_ff;
  int nxt_oc_cnt;
  always_comb begin
    nxt_oc_cnt = 0;
    if (oc_high_in[0] || oc_low_in[0]) begin
      nxt_oc_cnt = (oc_cnt_ff < 1000) ? oc_cnt_ff + 1 : oc_cnt_ff;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      oc_cnt_ff <= 0;
    end else begin
      oc_cnt_ff <= nxt_oc_cnt;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_trip;
    $fell(|bridge_a_gate);
  endsequence
  sequence s_cfg_rd;
    reg_wr && reg_addr == 4'h0 && reg_wdata[0] ##1 reg_rd && reg_addr == 4'h4;
  endsequence
  property p_rst_state;
    $rose(arst_n) |-> $past(bridge_a_gate) == 4'h5 && $past(drv_c_low_gate) == 4'h0;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("bad reset drive");
  property p_dead;
    $fell(drv_c_low_gate[0]) |-> !drv_c_low_gate[1] [*3];
  endproperty
  a_dead: assert property (p_dead) else $error("no dead time");
  property p_core_off;
    core_tsd_in [*5] |-> !core_reg_en;
  endproperty
  a_core_off: assert property (p_core_off) else $error("core on hot");
  property p_linear;
    reg5_mode_select [*5] |-> reg5_linear_mode && !reg5_switch;
  endproperty
  a_linear: assert property (p_linear) else $error("5v mode wrong");
  property p_tsd;
    drv_tsd_in[1] [*5] |-> bridge_b_gate == 4'h0;
  endproperty
  a_tsd: assert property (p_tsd) else $error("bridge b on hot");
  property p_pwm_low;
    !bridge_a_pwm_in [*5] |-> !bridge_a_gate.hs1 && !bridge_a_gate.hs2;
  endproperty
  a_pwm_low: assert property (p_pwm_low) else $error("high side on");
  property p_deglitch;
    s_trip |-> oc_cnt_ff >= DEGLITCH_CYC || $past(drv_tsd_in[0], 3);
  endproperty
  a_deglitch: assert property (p_deglitch) else $error("early trip");
  property p_offtime;
    s_trip |-> !(|bridge_a_gate) [*8];
  endproperty
  a_offtime: assert property (p_offtime) else $error("off too short");
  property p_cfg_load;
    s_cfg_rd |=> reg_rdata == {16'h0, $past(reg_wdata[15:0], 2)};
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config lost");
endmodule // mbc_top_checker
`default_nettype wire

// ---- dv/mbc_host_model.sv ----
// host side: drives the four pwm pins
`timescale 1ns/10ps
`default_nettype none
module mbc_host_model #(
  parameter int PERIOD_CYC = 6250
) (
  input  wire logic       clock,
  input  wire logic       run,
  input  wire logic [3:0] level,
  output var  logic       bridge_a_pwm_in,
  output var  logic       bridge_b_pwm_in,
  output var  logic       drv_c_pwm_in_a,
  output var  logic       drv_c_pwm_in_b
);
  int   cnt = 0;
  logic sq;
  always @(posedge clock) begin
    cnt <= (run && cnt < PERIOD_CYC - 1) ? cnt + 1 : 0;
  end
  // 40 kHz square on bridge a/b pins when running; driver c pins always static levels
  assign sq = cnt < PERIOD_CYC / 2;
  assign bridge_a_pwm_in = run ? sq : level[0];
  assign bridge_b_pwm_in = run ? sq : level[1];
  assign drv_c_pwm_in_a  = level[2];
  assign drv_c_pwm_in_b  = level[3];
endmodule // mbc_host_model
`default_nettype wire

// ---- dv/mbc_top_test.sv ----
// self-checking bench for motor bridge control
`timescale 1ns/10ps
`default_nettype none
module mbc_top_test;
  import mbc_pkg::*;
  logic             clock, arst_n, reg_wr, reg_rd, run, pr_up, pr_dn;
  logic             core_tsd_in, supply_over_20v_in, v33_stable_in;
  logic             reg5_mode_select, fb5, fb33, dca, dcb, lin, sw5, sw33, cen;
  logic [3:0]       reg_addr, level, lowg;
  logic [31:0]      reg_wdata, reg_rdata, rd_val;
  logic             bp_a, bp_b, cp_a, cp_b;
  logic [2:0]       oc_high_in, oc_low_in, drv_tsd_in;
  mbc_gate_type     ga, gb;
  mbc_setpoint_type sp;
  mbc_setpoint_type sp_exp [3] = '{MBC_SP_1V5, MBC_SP_1V8, MBC_SP_2V5};
  int               n_fail, comparisons, n;
  always #2 clock = ~clock;
  mbc_top #(.DEGLITCH_CYC(8), .DEAD_CYC(4), .OSC_CYC(16), .OFF_TICKS(3)) i_dut (
    .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bridge_a_pwm_in(bp_a), .bridge_b_pwm_in(bp_b),
    .drv_c_pwm_in_a(cp_a), .drv_c_pwm_in_b(cp_b), .oc_high_in(oc_high_in),
    .oc_low_in(oc_low_in), .drv_tsd_in(drv_tsd_in), .core_tsd_in(core_tsd_in),
    .supply_over_20v_in(supply_over_20v_in), .v33_stable_in(v33_stable_in),
    .reg5_mode_select(reg5_mode_select), .core_sel_probe_up_in(pr_up),
    .core_sel_probe_dn_in(pr_dn), .reg5_fb_high_in(fb5),
    .reg33_fb_high_in(fb33), .bridge_a_gate(ga), .bridge_b_gate(gb),
    .drv_c_dc_out_a(dca), .drv_c_dc_out_b(dcb), .drv_c_low_gate(lowg),
    .reg5_linear_mode(lin), .reg5_switch(sw5), .reg33_switch(sw33),
    .core_reg_en(cen), .core_reg_setpoint_select(sp));
  mbc_host_model #(.PERIOD_CYC(6250)) i_host (.clock(clock), .run(run),
    .level(level), .bridge_a_pwm_in(bp_a), .bridge_b_pwm_in(bp_b),
    .drv_c_pwm_in_a(cp_a), .drv_c_pwm_in_b(cp_b));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // leaves the bench at a falling edge with outputs settled
  task automatic cyc(input int k);
    @(posedge clock);
    reg_wr <= 1'b0;
    repeat (k - 1) @(posedge clock);
    @(negedge clock);
  endtask
  // a write must be followed by rd or cyc, which drop the strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rd_val = reg_rdata;
  endtask
  task automatic rst(input logic up, input logic dn);
    @(posedge clock);
    arst_n <= 1'b0;
    pr_up <= up;
    pr_dn <= dn;
    repeat (9) @(posedge clock);
    @(negedge clock);
    chk(ga, 32'h5);
    chk(lowg, 32'h0);
    @(posedge clock);
    arst_n <= 1'b1;
    cyc(8);
  endtask
  task automatic end_sim;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    {reg_wr, reg_rd, run, pr_up, pr_dn, core_tsd_in, fb5, fb33} = '0;
    {supply_over_20v_in, reg5_mode_select, oc_high_in, oc_low_in} = '0;
    {reg_addr, level, reg_wdata, drv_tsd_in} = '0;
    v33_stable_in = 1'b1;
    for (int i = 0; i < 3; i++) begin
      rst(i > 0, i == 1);
      chk(sp, sp_exp[i]);
    end
    rd(4'h4);
    chk(rd_val, 32'h1);
    rd(4'h1);
    chk(rd_val, 32'h0);
    chk(cen, 32'h1);
    @(posedge clock);
    core_tsd_in <= 1'b1;
    cyc(6);
    chk(cen, 32'h0);
    rd(4'h8);
    chk(rd_val, 32'h40);
    @(posedge clock);
    core_tsd_in <= 1'b0;
    cyc(6);
    wr(4'h8, 32'h40);
    rd(4'h8);
    chk(rd_val, 32'h0);
    for (int f = 0; f < 2; f++) begin
      @(posedge clock);
      fb5 <= f[0];
      fb33 <= f[0];
      // let a pulse launched before the feedback change run out
      cyc(24);
      n = 0;
      repeat (64) begin
        @(negedge clock);
        n += sw5 + sw33;
      end
      chk(n != 0, f == 0);
    end
    @(posedge clock);
    reg5_mode_select <= 1'b1;
    cyc(6);
    chk({lin, sw5}, 32'h2);
    @(posedge clock);
    run <= 1'b1;
    cyc(100);
    chk({ga, gb}, 32'h99);
    cyc(3125);
    chk({ga, gb}, 32'h11);
    wr(4'h0, 32'h8000);
    cyc(4);
    chk(ga, 32'h4);
    cyc(3100);
    chk(ga, 32'h6);
    @(posedge clock);
    run <= 1'b0;
    level <= 4'h1;
    oc_low_in[0] <= 1'b1;
    cyc(4);
    @(posedge clock);
    oc_low_in[0] <= 1'b0;
    cyc(6);
    chk(ga, 32'h6);
    @(posedge clock);
    oc_high_in[0] <= 1'b1;
    cyc(14);
    chk(ga, 32'h0);
    @(posedge clock);
    oc_high_in[0] <= 1'b0;
    cyc(16);
    chk(ga, 32'h0);
    rd(4'h8);
    chk(rd_val, 32'h1);
    cyc(40);
    chk(ga, 32'h6);
    @(posedge clock);
    drv_tsd_in[1] <= 1'b1;
    level <= 4'h5;
    cyc(12);
    chk(gb, 32'h0);
    chk(lowg, 32'h9);
    wr(4'h8, 32'h7F);
    rd(4'h8);
    chk(rd_val, 32'h10);
    @(posedge clock);
    drv_tsd_in[1] <= 1'b0;
    level <= 4'h1;
    cyc(4);
    chk(lowg, 32'h8);
    cyc(6);
    chk(lowg, 32'hA);
    @(posedge clock);
    supply_over_20v_in <= 1'b1;
    cyc(6);
    chk(lowg, 32'h0);
    @(posedge clock);
    supply_over_20v_in <= 1'b0;
    level <= 4'h5;
    wr(4'h0, 32'h2001);
    rd(4'h4);
    chk(rd_val, 32'h2001);
    rd(4'hC);
    chk(rd_val[0], 32'h1);
    cyc(6);
    chk({dca, dcb}, 32'h2);
    @(posedge clock);
    level <= 4'h1;
    wr(4'h0, 32'h1600);
    cyc(6);
    chk({dca, dcb, lowg}, 32'h2E);
    end_sim();
  end
endmodule // mbc_top_test
bind mbc_top mbc_top_checker #(.DEGLITCH_CYC(DEGLITCH_CYC)) i_chk (
  .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .bridge_a_pwm_in(bridge_a_pwm_in),
  .oc_high_in(oc_high_in), .oc_low_in(oc_low_in), .drv_tsd_in(drv_tsd_in),
  .core_tsd_in(core_tsd_in), .reg5_mode_select(reg5_mode_select),
  .bridge_a_gate(bridge_a_gate), .bridge_b_gate(bridge_b_gate),
  .drv_c_low_gate(drv_c_low_gate), .reg5_linear_mode(reg5_linear_mode),
  .reg5_switch(reg5_switch), .core_reg_en(core_reg_en));
`default_nettype wire
